// ===== logic/fpet_defs.vh
// Constants for the flash program/erase interval timer: register offsets,
// field positions, reset values and fixed multipliers.
// Included by every design file; definitions only.
`ifndef FPET_DEFS_VH
`define FPET_DEFS_VH

// Register byte offsets, main set at 0x00, secondary set at 0x40
`define FPET_SET_STRIDE      8'h40
`define FPET_OFF_PRESCALE    8'h00
`define FPET_OFF_START       8'h04
`define FPET_OFF_TRANSITION  8'h08
`define FPET_OFF_PROGRAM     8'h0c
`define FPET_OFF_PAGE_ERASE  8'h10
`define FPET_OFF_MODULE_ERS  8'h14
`define FPET_OFF_END_HOLD    8'h18
`define FPET_OFF_MODULE_END  8'h1c
`define FPET_OFF_RECOVERY    8'h20
`define FPET_OFF_CONTROL     8'h80
`define FPET_OFF_STATUS      8'h84

// Control register fields
`define FPET_CTL_GO_BIT      0
`define FPET_CTL_SEL_BIT     1
`define FPET_CTL_OP_LSB      4
`define FPET_CTL_OP_MSB      5

// Operation codes
`define FPET_OP_PROGRAM      2'h0
`define FPET_OP_PAGE_ERASE   2'h1
`define FPET_OP_MODULE_ERASE 2'h2

// Status register fields
`define FPET_ST_BUSY_BIT     0
`define FPET_ST_DONE_BIT     1
`define FPET_ST_ERR_BIT      2
`define FPET_ST_STATE_LSB    4

// Interval register width and reset value
`define FPET_CNT_W           16
`define FPET_CNT_RST         16'h0000

// Fixed multipliers as shift amounts: 8 and 4096 base ticks
`define FPET_MUL8_SHIFT      3
`define FPET_MUL4096_SHIFT   12

// AXI responses
`define FPET_RESP_OKAY       2'h0
`define FPET_RESP_SLVERR     2'h2

`endif

// ===== logic/fpet_regset.v
// One set of prescale and interval registers for one flash array.
// Assumes the parent decodes the word offset and gives a one-cycle write.
`timescale 1ns/10ps
`include "fpet_defs.vh"

module fpet_regset
#(
   parameter CW = `FPET_CNT_W
)
(
   input  wire              i_sys_clk,
   input  wire              i_srst,
   input  wire              i_wr,
   input  wire [3:0]        i_idx,
   input  wire [CW-1:0]     i_wdata,
   input  wire [3:0]        i_rd_idx,
   output reg  [CW-1:0]     o_rdata,
   output wire [9*CW-1:0]   o_flat
);

   reg [CW-1:0] regs_r [0:8];

   // Nine word registers, written by index
   genvar g;
   generate
      for (g = 0; g < 9; g = g + 1)
      begin : g_reg
         always @(posedge i_sys_clk)
         begin
            if (i_srst)
               regs_r[g] <= `FPET_CNT_RST;
            else if (i_wr && (i_idx == g))
               regs_r[g] <= i_wdata;
         end
         assign o_flat[g*CW +: CW] = regs_r[g];
      end
   endgenerate

   // Registered read data; indices past the set read zero
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
         o_rdata <= {CW{1'b0}};
      else if (i_rd_idx < 4'h9)
         o_rdata <= regs_r[i_rd_idx];
      else
         o_rdata <= {CW{1'b0}};
   end

endmodule

// ===== logic/fpet_ticker.v
// Base tick generator: one pulse every (prescale + 1) system clocks.
// Assumes the prescale value is stable while the sequence runs.
`timescale 1ns/10ps
`include "fpet_defs.vh"

module fpet_ticker
#(
   parameter CW = `FPET_CNT_W
)
(
   input  wire              i_sys_clk,
   input  wire              i_srst,
   input  wire              i_run,
   input  wire [CW-1:0]     i_prescale,
   output wire              o_tick
);

   reg [CW-1:0] div_r;

   // Restart on each run so the first tick is a full base period
   always @(posedge i_sys_clk)
   begin
      if (i_srst || !i_run)
         div_r <= {CW{1'b0}};
      else if (div_r >= i_prescale)
         div_r <= {CW{1'b0}};
      else
         div_r <= div_r + {{(CW-1){1'b0}}, 1'b1};
   end

   assign o_tick = i_run && (div_r >= i_prescale);

endmodule

// ===== logic/fpet_top.v
// Flash program/erase interval timer with AXI4-Lite register access.
// Assumes the flash array samples the strobe and pulse outputs on i_sys_clk.
`timescale 1ns/10ps
`include "fpet_defs.vh"

module fpet_top
#(
   parameter CW = `FPET_CNT_W
)
(
   input  wire              i_sys_clk,
   input  wire              i_srst,
   input  wire [7:0]        i_s_axi_awaddr,
   input  wire              i_s_axi_awvalid,
   output wire              o_s_axi_awready,
   input  wire [31:0]       i_s_axi_wdata,
   input  wire [3:0]        i_s_axi_wstrb,
   input  wire              i_s_axi_wvalid,
   output wire              o_s_axi_wready,
   output reg  [1:0]        o_s_axi_bresp,
   output reg               o_s_axi_bvalid,
   input  wire              i_s_axi_bready,
   input  wire [7:0]        i_s_axi_araddr,
   input  wire              i_s_axi_arvalid,
   output wire              o_s_axi_arready,
   output reg  [31:0]       o_s_axi_rdata,
   output reg  [1:0]        o_s_axi_rresp,
   output reg               o_s_axi_rvalid,
   input  wire              i_s_axi_rready,
   output reg               o_main_select,
   output reg               o_secondary_select,
   output reg               o_erase_mode,
   output reg               o_module_erase_mode,
   output reg               o_nonvolatile_store_strobe,
   output reg               o_program_pulse,
   output reg               o_erase_pulse,
   output reg               o_busy
);

   // Sequencer states
   localparam ST_IDLE  = 3'h0;
   localparam ST_SETUP = 3'h1;
   localparam ST_TRAN  = 3'h2;
   localparam ST_PULSE = 3'h3;
   localparam ST_HOLD  = 3'h4;
   localparam ST_RCV   = 3'h5;
   localparam PW       = CW + 12;

   // Register index inside a set
   localparam [3:0] IX_PRESC = 4'h0;
   localparam [3:0] IX_START = 4'h1;
   localparam [3:0] IX_TRAN  = 4'h2;
   localparam [3:0] IX_PROG  = 4'h3;
   localparam [3:0] IX_PERS  = 4'h4;
   localparam [3:0] IX_MERS  = 4'h5;
   localparam [3:0] IX_END   = 4'h6;
   localparam [3:0] IX_MEND  = 4'h7;
   localparam [3:0] IX_RCV   = 4'h8;

   // Decodes an offset into set membership; used for reads and writes
   function [5:0] dec_addr;
      input [7:0] a;
      begin
         if (a < 8'h24)
            dec_addr = {2'b01, a[5:2]};
         else if ((a >= `FPET_SET_STRIDE) && (a < 8'h64))
            dec_addr = {2'b10, a[5:2] ^ 4'h0};
         else
            dec_addr = 6'h00;
      end
   endfunction

   wire [9*CW-1:0] main_flat;
   wire [9*CW-1:0] sec_flat;
   wire [CW-1:0]   main_rdata;
   wire [CW-1:0]   sec_rdata;
   wire            tick;

   reg  [2:0]      state_r;
   reg  [PW-1:0]   cnt_r;
   reg  [2:0]      shift_r;
   reg             sel_r;
   reg  [1:0]      op_r;
   reg             done_r;
   reg             err_r;

   reg  [7:0]      aw_addr_r;
   reg             aw_full_r;
   reg  [31:0]     w_data_r;
   reg  [3:0]      w_strb_r;
   reg             w_full_r;
   reg  [1:0]      rd_kind_r;
   reg             rd_pend_r;

   // Write path: address and data taken independently, one write at a time
   assign o_s_axi_awready = !aw_full_r && !o_s_axi_bvalid;
   assign o_s_axi_wready  = !w_full_r && !o_s_axi_bvalid;
   assign o_s_axi_arready = !rd_pend_r && !o_s_axi_rvalid;

   wire       wr_go   = aw_full_r && w_full_r && !o_s_axi_bvalid;
   wire [5:0] wdec    = dec_addr(aw_addr_r);
   wire       wr_ctl  = wr_go && (aw_addr_r == `FPET_OFF_CONTROL);
   wire       wr_main = wr_go && wdec[4] && !o_busy;
   wire       wr_sec  = wr_go && wdec[5] && !o_busy;
   wire [5:0] rdec    = dec_addr(i_s_axi_araddr);
   wire       go_req  = wr_ctl && w_strb_r[0] && w_data_r[`FPET_CTL_GO_BIT];
   wire [1:0] go_op   = w_data_r[`FPET_CTL_OP_MSB:`FPET_CTL_OP_LSB];

   fpet_regset #(.CW(CW)) u_main
   (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_wr      (wr_main),
      .i_idx     (wdec[3:0]),
      .i_wdata   (w_data_r[CW-1:0]),
      .i_rd_idx  (rdec[3:0]),
      .o_rdata   (main_rdata),
      .o_flat    (main_flat)
   );

   fpet_regset #(.CW(CW)) u_sec
   (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_wr      (wr_sec),
      .i_idx     (wdec[3:0]),
      .i_wdata   (w_data_r[CW-1:0]),
      .i_rd_idx  (rdec[3:0]),
      .o_rdata   (sec_rdata),
      .o_flat    (sec_flat)
   );

   // Each array steers its own prescale while selected; in idle the pending control word picks the set,
   // so the setup count loaded at start comes from the array being started, not the previous one
   wire [9*CW-1:0] act_flat = ((state_r == ST_IDLE) ? w_data_r[`FPET_CTL_SEL_BIT] : sel_r) ? sec_flat : main_flat;
   wire [CW-1:0]   presc    = act_flat[IX_PRESC*CW +: CW];

   fpet_ticker #(.CW(CW)) u_tick
   (
      .i_sys_clk  (i_sys_clk),
      .i_srst     (i_srst),
      .i_run      (o_busy),
      .i_prescale (presc),
      .o_tick     (tick)
   );

   // AXI write channel capture and response
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         aw_full_r      <= 1'b0;
         w_full_r       <= 1'b0;
         aw_addr_r      <= 8'h00;
         w_data_r       <= 32'h0000_0000;
         w_strb_r       <= 4'h0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp  <= `FPET_RESP_OKAY;
      end
      else
      begin
         if (i_s_axi_awvalid && o_s_axi_awready)
         begin
            aw_addr_r <= {i_s_axi_awaddr[7:2], 2'b00};
            aw_full_r <= 1'b1;
         end
         if (i_s_axi_wvalid && o_s_axi_wready)
         begin
            w_data_r <= i_s_axi_wdata;
            w_strb_r <= i_s_axi_wstrb;
            w_full_r <= 1'b1;
         end
         if (wr_go)
         begin
            aw_full_r      <= 1'b0;
            w_full_r       <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            // Unmapped offsets and interval writes during a run get SLVERR
            if ((wdec[5:4] != 2'b00 && !o_busy) || wr_ctl)
               o_s_axi_bresp <= `FPET_RESP_OKAY;
            else
               o_s_axi_bresp <= `FPET_RESP_SLVERR;
         end
         else if (o_s_axi_bvalid && i_s_axi_bready)
            o_s_axi_bvalid <= 1'b0;
      end
   end

   // AXI read: set data come registered one cycle after address
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         rd_pend_r      <= 1'b0;
         rd_kind_r      <= 2'h0;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata  <= 32'h0000_0000;
         o_s_axi_rresp  <= `FPET_RESP_OKAY;
      end
      else if (i_s_axi_arvalid && o_s_axi_arready)
      begin
         rd_pend_r <= 1'b1;
         if (rdec[5:4] != 2'b00)
            rd_kind_r <= {1'b0, rdec[5]};
         else if (i_s_axi_araddr[7:2] == `FPET_OFF_STATUS >> 2)
            rd_kind_r <= 2'h2;
         else if (i_s_axi_araddr[7:2] == `FPET_OFF_CONTROL >> 2)
            rd_kind_r <= 2'h3;
         else
            rd_kind_r <= 2'h0;
         o_s_axi_rresp <= (rdec[5:4] != 2'b00 || i_s_axi_araddr[7:3] == 5'h10)
                          ? `FPET_RESP_OKAY : `FPET_RESP_SLVERR;
      end
      else if (rd_pend_r)
      begin
         rd_pend_r      <= 1'b0;
         o_s_axi_rvalid <= 1'b1;
         if (o_s_axi_rresp != `FPET_RESP_OKAY)
            o_s_axi_rdata <= 32'h0000_0000;
         else if (rd_kind_r == 2'h2)
            o_s_axi_rdata <= {25'h0, state_r, 1'b0, err_r, done_r, o_busy};
         else if (rd_kind_r == 2'h3)
            o_s_axi_rdata <= {26'h0, op_r, 2'b00, sel_r, o_busy};
         else
            o_s_axi_rdata <= {{(32-CW){1'b0}}, rd_kind_r[0] ? sec_rdata : main_rdata};
      end
      else if (o_s_axi_rvalid && i_s_axi_rready)
         o_s_axi_rvalid <= 1'b0;
   end

   // Phase length in base ticks minus one, for the active array
   reg [PW-1:0] load_val;
   reg [CW-1:0] sel_cnt;
   reg [3:0]    sel_shift;
   always @*
   begin
      sel_cnt   = {CW{1'b0}};
      sel_shift = 4'h0;
      case (state_r)
         ST_IDLE:  sel_cnt = act_flat[IX_START*CW +: CW];
         ST_SETUP: sel_cnt = act_flat[IX_TRAN*CW +: CW];
         ST_TRAN:
         begin
            if (op_r == `FPET_OP_PROGRAM)
            begin
               sel_cnt   = act_flat[IX_PROG*CW +: CW];
               sel_shift = 4'd`FPET_MUL8_SHIFT;
            end
            else if (op_r == `FPET_OP_PAGE_ERASE)
            begin
               sel_cnt   = act_flat[IX_PERS*CW +: CW];
               sel_shift = 4'd`FPET_MUL4096_SHIFT;
            end
            else
            begin
               sel_cnt   = act_flat[IX_MERS*CW +: CW];
               sel_shift = 4'd`FPET_MUL4096_SHIFT;
            end
         end
         ST_PULSE:
         begin
            if (op_r == `FPET_OP_MODULE_ERASE)
            begin
               sel_cnt   = act_flat[IX_MEND*CW +: CW];
               sel_shift = 4'd`FPET_MUL8_SHIFT;
            end
            else
               sel_cnt = act_flat[IX_END*CW +: CW];
         end
         ST_HOLD:  sel_cnt = act_flat[IX_RCV*CW +: CW];
         default:  sel_cnt = {CW{1'b0}};
      endcase
      // (count + 1) * multiplier - 1 base ticks remaining after this one
      load_val = ((({{12{1'b0}}, sel_cnt}) + {{(PW-1){1'b0}}, 1'b1}) << sel_shift)
                 - {{(PW-1){1'b0}}, 1'b1};
   end

   // Sequencer: setup, strobe, transition, pulse, hold, recovery, idle
   always @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         state_r <= ST_IDLE;
         cnt_r   <= {PW{1'b0}};
         sel_r   <= 1'b0;
         op_r    <= `FPET_OP_PROGRAM;
         done_r  <= 1'b0;
         err_r   <= 1'b0;
         o_busy  <= 1'b0;
         o_main_select              <= 1'b0;
         o_secondary_select         <= 1'b0;
         o_erase_mode               <= 1'b0;
         o_module_erase_mode        <= 1'b0;
         o_nonvolatile_store_strobe <= 1'b0;
         o_program_pulse            <= 1'b0;
         o_erase_pulse              <= 1'b0;
      end
      else
      begin
         // Done and error clear on a control write while not busy; a new event wins
         if (wr_ctl && !o_busy)
         begin
            done_r <= 1'b0;
            err_r  <= 1'b0;
         end
         case (state_r)
            ST_IDLE:
            begin
               if (go_req && go_op == 2'h3)
                  err_r <= 1'b1;
               else if (go_req)
               begin
                  sel_r   <= w_data_r[`FPET_CTL_SEL_BIT];
                  op_r    <= go_op;
                  o_busy  <= 1'b1;
                  o_main_select       <= !w_data_r[`FPET_CTL_SEL_BIT];
                  o_secondary_select  <= w_data_r[`FPET_CTL_SEL_BIT];
                  o_erase_mode        <= (go_op != `FPET_OP_PROGRAM);
                  o_module_erase_mode <= (go_op == `FPET_OP_MODULE_ERASE);
                  state_r <= ST_SETUP;
               end
            end
            ST_SETUP, ST_TRAN, ST_PULSE, ST_HOLD, ST_RCV:
            begin
               if (tick && cnt_r == {PW{1'b0}})
               begin
                  cnt_r <= load_val;
                  case (state_r)
                     ST_SETUP:
                     begin
                        o_nonvolatile_store_strobe <= 1'b1;
                        state_r <= ST_TRAN;
                     end
                     ST_TRAN:
                     begin
                        o_program_pulse <= (op_r == `FPET_OP_PROGRAM);
                        o_erase_pulse   <= (op_r != `FPET_OP_PROGRAM);
                        state_r <= ST_PULSE;
                     end
                     ST_PULSE:
                     begin
                        o_program_pulse <= 1'b0;
                        o_erase_pulse   <= 1'b0;
                        state_r <= ST_HOLD;
                     end
                     ST_HOLD:
                     begin
                        o_nonvolatile_store_strobe <= 1'b0;
                        state_r <= ST_RCV;
                     end
                     default:
                     begin
                        // Recovery over: array free again
                        cnt_r   <= {PW{1'b0}};
                        o_busy  <= 1'b0;
                        done_r  <= 1'b1;
                        o_main_select       <= 1'b0;
                        o_secondary_select  <= 1'b0;
                        o_erase_mode        <= 1'b0;
                        o_module_erase_mode <= 1'b0;
                        state_r <= ST_IDLE;
                     end
                  endcase
               end
               else if (tick)
                  cnt_r <= cnt_r - {{(PW-1){1'b0}}, 1'b1};
            end
            default: state_r <= ST_IDLE;
         endcase
         // Setup count loads as the run begins
         if (state_r == ST_IDLE && go_req && go_op != 2'h3)
            cnt_r <= load_val;
      end
   end

endmodule

// ===== sim/fpet_flash_model.sv
// Flash array stand-in: timestamps every phase edge of the timer's outputs.
// Assumes all outputs it watches change on i_sys_clk rising edges.
`timescale 1ns/10ps
module fpet_flash_model
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_busy,
   input  wire logic        i_secondary_select,
   input  wire logic        i_module_erase_mode,
   input  wire logic        i_strobe,
   input  wire logic        i_program_pulse,
   input  wire logic        i_erase_pulse,
   output logic [5:0][31:0] o_ts,
   output logic      [3:0]  o_kind,
   output logic      [31:0] o_runs = 32'h0,
   output logic      [31:0] o_faults = 32'h0
);
   logic [31:0] cyc_r = 32'h0;
   logic        busy_q = 1'b0;
   logic        strobe_q = 1'b0;
   logic        pulse_q = 1'b0;
   wire         pulse = i_program_pulse | i_erase_pulse;

   // Edge stamps; differences give phase lengths in clocks
   always @(posedge i_sys_clk)
   begin
      cyc_r <= cyc_r + 32'h1;
      busy_q <= i_busy;
      strobe_q <= i_strobe;
      pulse_q <= pulse;
      if (i_busy && !busy_q) o_ts[0] <= cyc_r;
      if (i_strobe && !strobe_q) o_ts[1] <= cyc_r;
      if (pulse && !pulse_q)
      begin
         o_ts[2] <= cyc_r;
         o_kind <= {i_secondary_select, i_module_erase_mode, i_erase_pulse, i_program_pulse};
      end
      if (!pulse && pulse_q) o_ts[3] <= cyc_r;
      if (!i_strobe && strobe_q) o_ts[4] <= cyc_r;
      if (!i_busy && busy_q)
      begin
         o_ts[5] <= cyc_r;
         o_runs <= o_runs + 32'h1;
      end
      // The cells are only safe if the high voltage sits under the strobe
      if ((pulse && !i_strobe) || (i_strobe && !i_busy)) o_faults <= o_faults + 32'h1;
   end
endmodule

// ===== sim/fpet_properties.sv
// Concurrent checks on the array-side outputs of the flash interval timer.
// Assumes it is bound to fpet_top and sees only that module's ports.
`timescale 1ns/10ps
module fpet_properties
(
   input wire logic       i_sys_clk,
   input wire logic       i_srst,
   input wire logic       o_busy,
   input wire logic       o_main_select,
   input wire logic       o_secondary_select,
   input wire logic       o_erase_mode,
   input wire logic       o_module_erase_mode,
   input wire logic       o_nonvolatile_store_strobe,
   input wire logic       o_program_pulse,
   input wire logic       o_erase_pulse,
   input wire logic       o_s_axi_bvalid,
   input wire logic [1:0] o_s_axi_bresp
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   // Phase ordering: strobe inside a run, pulses inside the strobe
   strobe_in_run_a: assert property (o_nonvolatile_store_strobe |-> o_busy)
      else $error("strobe high while idle");
   pulse_in_strobe_a: assert property ((o_program_pulse || o_erase_pulse) |-> o_nonvolatile_store_strobe)
      else $error("pulse without strobe");
   strobe_leads_a: assert property ($rose(o_program_pulse || o_erase_pulse) |-> $past(o_nonvolatile_store_strobe))
      else $error("pulse rose with strobe");
   setup_first_a: assert property ($rose(o_nonvolatile_store_strobe) |->
      $past(o_busy) && !o_program_pulse && !o_erase_pulse)
      else $error("strobe rose without setup");
   hold_after_a: assert property ($fell(o_program_pulse || o_erase_pulse) |-> o_nonvolatile_store_strobe)
      else $error("strobe dropped with pulse");
   recovery_after_a: assert property ($fell(o_nonvolatile_store_strobe) |-> o_busy)
      else $error("no recovery after strobe");
   // Pulse kind follows the mode, and minimum program and erase widths of 7 and 8 clocks
   prog_kind_a: assert property (o_program_pulse |-> !o_erase_mode && !o_erase_pulse)
      else $error("program pulse in erase mode");
   erase_kind_a: assert property (o_erase_pulse |-> o_erase_mode)
      else $error("erase pulse in program mode");
   prog_width_a: assert property ($rose(o_program_pulse) |-> o_program_pulse[*7])
      else $error("program pulse too short");
   erase_width_a: assert property ($rose(o_erase_pulse) |-> o_erase_pulse[*8])
      else $error("erase pulse too short");
   one_array_a: assert property (o_busy |-> (o_main_select ^ o_secondary_select))
      else $error("array select not unique");
   mode_steady_a: assert property (o_busy && $past(o_busy) |-> $stable(o_erase_mode) && $stable(o_module_erase_mode))
      else $error("mode changed mid run");

   // Main scenarios reached
   prog_seen_c: cover property ($rose(o_program_pulse));
   module_seen_c: cover property ($rose(o_erase_pulse) && o_module_erase_mode);
   refused_seen_c: cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
endmodule

// ===== sim/test_flash_program_erase_timer.sv
// Self-checking bench: AXI4-Lite master tasks plus phase timing checks.
// Assumes fpet_top with the register map of fpet_defs.vh.
`timescale 1ns/10ps
`include "fpet_defs.vh"
`define CHK(g, e, t) begin total_checks++; \
   if (((g) !== (e)) && !((t) != 0 && ((g) + (t) >= (e)) === 1'b1 && ((g) <= (e) + (t)) === 1'b1)) \
   begin miscompares++; $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_flash_program_erase_timer;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        awready, wready, arready, bvalid, rvalid;
   logic [1:0]  bresp, rresp;
   logic        msel, ssel, emode, mmode, strobe, ppulse, epulse, busy;
   logic [5:0][31:0] ts;
   logic [3:0]  kind;
   logic [31:0] runs, faults, d;
   logic [1:0]  r;
   int          miscompares = 0, total_checks = 0, cyc = 0, i;
   // Interval sets: prescale, start, tran, prog, page, module, end, module end, recovery
   int          mainv [9] = '{1, 2, 1, 1, 0, 0, 2, 1, 3};
   int          secv [9] = '{0, 0, 0, 0, 0, 0, 1, 0, 0};

   always #5 clk = ~clk;

   fpet_top uut (.i_sys_clk(clk), .i_srst(srst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'b1),
      .o_main_select(msel), .o_secondary_select(ssel), .o_erase_mode(emode),
      .o_module_erase_mode(mmode), .o_nonvolatile_store_strobe(strobe), .o_program_pulse(ppulse),
      .o_erase_pulse(epulse), .o_busy(busy));

   fpet_flash_model u_flash (.i_sys_clk(clk), .i_busy(busy), .i_secondary_select(ssel),
      .i_module_erase_mode(mmode), .i_strobe(strobe), .i_program_pulse(ppulse), .i_erase_pulse(epulse),
      .o_ts(ts), .o_kind(kind), .o_runs(runs), .o_faults(faults));

   // Verdict and end of run, shared by the main sequence and the watchdog
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One write; ready low waits are fine because bready is held high throughout
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
   endtask

   // One read, data taken at the edge where rvalid is seen
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      resp = rresp;
   endtask

   // Start one sequence, optionally poke it while busy, then time its phases
   task automatic run(input logic sel, input logic [1:0] op, input logic [3:0] k, input logic poke,
                      input int e0, input int e1, input int e2, input int e3, input int e4);
      logic [31:0] n0;
      logic [31:0] v;
      logic [1:0]  rs;
      n0 = runs;
      axw(`FPET_OFF_CONTROL, {26'h0, op, 2'h0, sel, 1'b1}, rs);
      `CHK(rs, `FPET_RESP_OKAY, 0)
      if (poke)
      begin
         axw(`FPET_OFF_TRANSITION, 32'h5, rs);
         `CHK(rs, `FPET_RESP_SLVERR, 0)
         axr(`FPET_OFF_STATUS, v, rs);
         `CHK(v[0], 1'b1, 0)
         axr(`FPET_OFF_CONTROL, v, rs);
         `CHK(v[5:0], {op, 2'b00, sel, 1'b1}, 0)
      end
      while (runs == n0) @(posedge clk);
      `CHK(ts[1] - ts[0], e0, 1)
      `CHK(ts[2] - ts[1], e1, 1)
      `CHK(ts[3] - ts[2], e2, 1)
      `CHK(ts[4] - ts[3], e3, 1)
      `CHK(ts[5] - ts[4], e4, 1)
      `CHK(kind, k, 0)
      `CHK(faults, 32'h0, 0)
      axr(`FPET_OFF_STATUS, v, rs);
      `CHK(v[2:0], 3'b010, 0)
      $display("test run op %0d array %0d done", op, sel);
   endtask

   // Watchdog: the whole run needs about 12600 clocks
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         miscompares++;
         end_sim();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      // Reset values of both sets, read-back width, refused addresses
      for (i = 0; i < 18; i++)
      begin
         axr((i / 9) * `FPET_SET_STRIDE + (i % 9) * 4, d, r);
         `CHK(d, 32'h0, 0)
      end
      axw(`FPET_OFF_START, 32'h1234abcd, r);
      axr(`FPET_OFF_START, d, r);
      `CHK(d, 32'h0000abcd, 0)
      axr(8'h3c, d, r);
      `CHK({d, r}, {32'h0, `FPET_RESP_SLVERR}, 0)
      axw(`FPET_OFF_STATUS, 32'h1, r);
      `CHK(r, `FPET_RESP_SLVERR, 0)
      $display("test registers done");
      // Small counts keep every run far inside the high-voltage budget
      for (i = 0; i < 9; i++)
      begin
         axw(i * 4, mainv[i], r);
         axw(`FPET_SET_STRIDE + i * 4, secv[i], r);
      end
      run(1'b0, `FPET_OP_PROGRAM, 4'b0001, 1'b0, 6, 4, 32, 6, 8);
      run(1'b1, `FPET_OP_PAGE_ERASE, 4'b1010, 1'b0, 1, 1, 4096, 2, 1);
      run(1'b0, `FPET_OP_MODULE_ERASE, 4'b0110, 1'b1, 6, 4, 8192, 32, 8);
      // Illegal operation code flags an error and never starts
      axw(`FPET_OFF_CONTROL, 32'h31, r);
      axr(`FPET_OFF_STATUS, d, r);
      `CHK(d[2:0], 3'b100, 0)
      $display("test illegal op done");
      end_sim();
   end
endmodule

bind fpet_top fpet_properties u_props (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .o_busy(o_busy),
   .o_main_select(o_main_select), .o_secondary_select(o_secondary_select), .o_erase_mode(o_erase_mode),
   .o_module_erase_mode(o_module_erase_mode), .o_nonvolatile_store_strobe(o_nonvolatile_store_strobe),
   .o_program_pulse(o_program_pulse), .o_erase_pulse(o_erase_pulse), .o_s_axi_bvalid(o_s_axi_bvalid),
   .o_s_axi_bresp(o_s_axi_bresp));
